// [src/gmc_pkg.sv]
// shared types and constants for the gate enable and power mode controller
package gmc_pkg;
    // core clock period in ns
    localparam int CLK_PERIOD_NS = 4;
    // gate shut-off deadline after enable falls
    localparam int GATE_OFF_NS = 100;
    localparam int GATE_OFF_CYCLES = GATE_OFF_NS / CLK_PERIOD_NS;
    // least enable low time before a mode change
    localparam int ENABLE_LOW_NS = 1000000;
    localparam int ENABLE_LOW_CYCLES = (ENABLE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // least wake low time before a wake edge counts (plain default)
    localparam int WAKE_SETUP_NS = 1000;
    localparam int WAKE_SETUP_CYCLES = (WAKE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // counter widths
    localparam int LOW_CNT_W = 18;
    localparam int WAKE_CNT_W = 10;
    localparam int DEAD_CNT_W = 8;
    // number of gate outputs
    localparam int GATE_COUNT = 6;
    // reset values
    localparam logic [LOW_CNT_W-1:0] LOW_CNT_RST = 18'h00000;
    localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_RST = 10'h000;
    localparam logic [DEAD_CNT_W-1:0] DEAD_CNT_RST = 8'h00;
    localparam logic [DEAD_CNT_W-1:0] DEAD_CNT_MAX = 8'hFF;
    // high and low side pairs share a phase; mask picks high sides
    localparam logic [GATE_COUNT-1:0] HIGH_SIDE_MASK = 6'h2A;

    // six pwm commands, one per gate
    typedef struct packed {
        logic phase_a_high_cmd;
        logic phase_a_low_cmd;
        logic phase_b_high_cmd;
        logic phase_b_low_cmd;
        logic phase_c_high_cmd;
        logic phase_c_low_cmd;
    } gmc_phase_t;

    // six gate drive outputs, same order as the commands
    typedef struct packed {
        logic high_gate_a;
        logic low_gate_a;
        logic high_gate_b;
        logic low_gate_b;
        logic high_gate_c;
        logic low_gate_c;
    } gmc_gate_t;

    // power states, one-hot
    typedef enum logic [3:0] {
        ST_STARTUP = 4'h1,
        ST_ACTIVE = 4'h2,
        ST_STANDBY = 4'h4,
        ST_SLEEP = 4'h8
    } gmc_state_t;
endpackage

// [src/gmc_gate_enable_mode_control.sv]
// gate enable, fault latch and standby/sleep control for a three-phase gate driver
`timescale 1ns/10ps

module gmc_gate_enable_mode_control #(
    parameter int LOW_TIME_CYCLES = gmc_pkg::ENABLE_LOW_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic outputEnable,
    input wire gmc_pkg::gmc_phase_t pwmCmd,
    input wire logic wakeIn,
    input wire logic faultActive,
    input wire logic regulatorReady,
    input wire logic sleepSelect,
    input wire logic amplifier_shutdown_select,
    input wire logic [gmc_pkg::DEAD_CNT_W-1:0] deadTimeCfg,
    input wire logic faultPinIn,
    output gmc_pkg::gmc_gate_t gateDrive,
    output logic faultPinOut,
    output logic faultPinOe_n,
    output logic bootstrapSupplyEn,
    output logic chargePumpEn,
    output logic amplifierEn,
    output logic regulatorEn
);
    // synchroniser stages for enable, wake and pwm pins
    logic enSync1_reg;
    logic enSync2_reg;
    logic enPrev_reg;
    logic wakeSync1_reg;
    logic wakeSync2_reg;
    logic wakePrev_reg;
    logic [gmc_pkg::GATE_COUNT-1:0] pwmSync1_reg;
    logic [gmc_pkg::GATE_COUNT-1:0] pwmSync2_reg;
    // enable low timer and wake low timer
    logic [gmc_pkg::LOW_CNT_W-1:0] lowCnt_reg;
    logic [gmc_pkg::WAKE_CNT_W-1:0] wakeCnt_reg;
    // power state and fault latch
    gmc_pkg::gmc_state_t state_reg;
    logic faultLatch_reg;
    // registered outputs
    logic [gmc_pkg::GATE_COUNT-1:0] gate_reg;
    logic faultPinOe_n_reg;
    logic faultPinOut_reg;
    logic bootEn_reg;
    logic pumpEn_reg;
    logic ampEn_reg;
    logic regEn_reg;
    // decoded events
    logic enRise;
    logic lowDone;
    logic wakeOk;
    logic driveAllowed;
    // the observed fault pin level is not needed by this block
    logic faultPinSeen;

    localparam logic [gmc_pkg::LOW_CNT_W-1:0] LOW_LIMIT = gmc_pkg::LOW_CNT_W'(LOW_TIME_CYCLES);
    localparam logic [gmc_pkg::WAKE_CNT_W-1:0] WAKE_LIMIT = gmc_pkg::WAKE_CNT_W'(gmc_pkg::WAKE_SETUP_CYCLES);

    assign faultPinSeen = faultPinIn;
    assign enRise = enSync2_reg & ~enPrev_reg;
    assign lowDone = (lowCnt_reg == LOW_LIMIT);
    assign wakeOk = wakeSync2_reg & ~wakePrev_reg & (wakeCnt_reg > WAKE_LIMIT);
    // gates may only switch on while enabled and fully active
    assign driveAllowed = enSync2_reg & (state_reg == gmc_pkg::ST_ACTIVE);

    // pin synchronisers; reset to low so an idle pin reads inactive
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            enSync1_reg <= 1'b0;
            enSync2_reg <= 1'b0;
            enPrev_reg <= 1'b0;
            wakeSync1_reg <= 1'b0;
            wakeSync2_reg <= 1'b0;
            wakePrev_reg <= 1'b0;
            pwmSync1_reg <= '0;
            pwmSync2_reg <= '0;
        end else begin
            enSync1_reg <= outputEnable;
            enSync2_reg <= enSync1_reg;
            enPrev_reg <= enSync2_reg;
            wakeSync1_reg <= wakeIn;
            wakeSync2_reg <= wakeSync1_reg;
            wakePrev_reg <= wakeSync2_reg;
            pwmSync1_reg <= pwmCmd;
            pwmSync2_reg <= pwmSync1_reg;
        end
    end

    // enable low timer: counts low cycles, restarts when enable is high
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lowCnt_reg <= gmc_pkg::LOW_CNT_RST;
        end else if (enSync2_reg) begin
            lowCnt_reg <= gmc_pkg::LOW_CNT_RST;
        end else if (!lowDone) begin
            lowCnt_reg <= lowCnt_reg + 1'b1;
        end
    end

    // wake low timer: saturates just past the setup time
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wakeCnt_reg <= gmc_pkg::WAKE_CNT_RST;
        end else if (wakeSync2_reg) begin
            wakeCnt_reg <= gmc_pkg::WAKE_CNT_RST;
        end else if (wakeCnt_reg <= WAKE_LIMIT) begin
            wakeCnt_reg <= wakeCnt_reg + 1'b1;
        end
    end

    // power state machine
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg <= gmc_pkg::ST_STARTUP;
        end else begin
            case (state_reg)
                // regulator start-up in progress
                gmc_pkg::ST_STARTUP: begin
                    if (regulatorReady) begin
                        state_reg <= gmc_pkg::ST_ACTIVE;
                    end
                end
                // full operation; leave only after the full low time
                gmc_pkg::ST_ACTIVE: begin
                    if (!enSync2_reg && lowDone) begin
                        state_reg <= sleepSelect ? gmc_pkg::ST_SLEEP : gmc_pkg::ST_STANDBY;
                    end
                end
                // standby returns to active as soon as enable is high
                gmc_pkg::ST_STANDBY: begin
                    if (enSync2_reg) begin
                        state_reg <= gmc_pkg::ST_ACTIVE;
                    end
                end
                // sleep only ends on a qualified wake edge
                gmc_pkg::ST_SLEEP: begin
                    if (wakeOk) begin
                        state_reg <= gmc_pkg::ST_STARTUP;
                    end
                end
                default: begin
                    state_reg <= gmc_pkg::ST_STARTUP;
                end
            endcase
        end
    end

    // fault latch: a live fault sets it and beats a clear in the same cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            faultLatch_reg <= 1'b0;
        end else if (faultActive) begin
            faultLatch_reg <= 1'b1;
        end else if (enRise) begin
            faultLatch_reg <= 1'b0;
        end
    end

    // fault pin: drives low while latched or during start-up, else released
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            faultPinOe_n_reg <= 1'b0;
            faultPinOut_reg <= 1'b0;
        end else begin
            faultPinOe_n_reg <= ~(faultLatch_reg | (state_reg == gmc_pkg::ST_STARTUP));
            faultPinOut_reg <= 1'b0;
        end
    end

    // supply and amplifier enables from the power state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bootEn_reg <= 1'b0;
            pumpEn_reg <= 1'b0;
            ampEn_reg <= 1'b0;
            regEn_reg <= 1'b1;
        end else begin
            bootEn_reg <= (state_reg == gmc_pkg::ST_ACTIVE);
            pumpEn_reg <= (state_reg == gmc_pkg::ST_ACTIVE);
            ampEn_reg <= (state_reg == gmc_pkg::ST_ACTIVE)
                | ((state_reg == gmc_pkg::ST_STANDBY) & ~amplifier_shutdown_select);
            regEn_reg <= (state_reg != gmc_pkg::ST_SLEEP);
        end
    end

    // per-gate drive with optional dead time and shoot-through lockout
    genvar g;
    generate
        for (g = 0; g < gmc_pkg::GATE_COUNT; g++) begin : gateLane
            logic [gmc_pkg::DEAD_CNT_W-1:0] deadCnt_reg;
            logic opposite;
            logic request;
            assign opposite = pwmSync2_reg[g ^ 1];
            assign request = driveAllowed & pwmSync2_reg[g] & ~opposite;
            // dead-time counter runs while this gate is requested
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    deadCnt_reg <= gmc_pkg::DEAD_CNT_RST;
                end else if (!request) begin
                    deadCnt_reg <= gmc_pkg::DEAD_CNT_RST;
                end else if (deadCnt_reg != gmc_pkg::DEAD_CNT_MAX) begin
                    deadCnt_reg <= deadCnt_reg + 1'b1;
                end
            end
            // gate goes high once the dead time has elapsed
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    gate_reg[g] <= 1'b0;
                end else begin
                    gate_reg[g] <= request & (deadCnt_reg >= deadTimeCfg);
                end
            end
        end
    endgenerate

    assign gateDrive = gate_reg;
    assign faultPinOut = faultPinOut_reg;
    assign faultPinOe_n = faultPinOe_n_reg;
    assign bootstrapSupplyEn = bootEn_reg;
    assign chargePumpEn = pumpEn_reg;
    assign amplifierEn = ampEn_reg;
    assign regulatorEn = regEn_reg;

    // checks
    gatesOff_a:
    assert property (@(posedge core_clk) disable iff (reset)
        $fell(enSync2_reg) |=> (gate_reg == '0) [*2])
        else $error("gates not off after enable fell");

    noEarlyMode_a:
    assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == gmc_pkg::ST_ACTIVE) && !lowDone |=>
        !(state_reg inside {gmc_pkg::ST_STANDBY, gmc_pkg::ST_SLEEP}))
        else $error("mode change before full low time");

    timerRestart_a:
    assert property (@(posedge core_clk) disable iff (reset)
        $rose(enSync2_reg) |=> (lowCnt_reg == gmc_pkg::LOW_CNT_RST) && !lowDone)
        else $error("low timer not restarted");

    activeSupplies_a:
    assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == gmc_pkg::ST_ACTIVE) |=> bootEn_reg && pumpEn_reg && ampEn_reg)
        else $error("supplies off while active");

    standbySupplies_a:
    assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == gmc_pkg::ST_STANDBY) |=> !bootEn_reg && !pumpEn_reg)
        else $error("bootstrap or pump on in standby");

    standbyAmp_a:
    assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == gmc_pkg::ST_STANDBY) |=> ampEn_reg == !$past(amplifier_shutdown_select))
        else $error("amplifier enable wrong in standby");

    faultClear_a:
    assert property (@(posedge core_clk) disable iff (reset)
        (enRise && !faultActive) |=> !faultLatch_reg ##1 (faultPinOe_n_reg || $past(faultActive)
        || state_reg == gmc_pkg::ST_STARTUP || $past(state_reg == gmc_pkg::ST_STARTUP)))
        else $error("fault not cleared on enable rise");

    modeSelect_a:
    assert property (@(posedge core_clk) disable iff (reset)
        ((state_reg == gmc_pkg::ST_ACTIVE) && !enSync2_reg && lowDone) |=>
        state_reg == ($past(sleepSelect) ? gmc_pkg::ST_SLEEP : gmc_pkg::ST_STANDBY))
        else $error("wrong low power mode");

    noShoot_a:
    assert property (@(posedge core_clk) disable iff (reset)
        ((gate_reg & (gate_reg << 1)) & gmc_pkg::HIGH_SIDE_MASK) == '0)
        else $error("both sides of a phase on");

    startupFault_a:
    assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == gmc_pkg::ST_STARTUP) |=> !faultPinOe_n_reg && !faultPinOut_reg)
        else $error("fault pin released during start-up");

    sleepHold_a:
    assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == gmc_pkg::ST_SLEEP) && !wakeOk |=> state_reg == gmc_pkg::ST_SLEEP)
        else $error("left sleep without qualified wake");
endmodule

// [bench/gmc_host_model.sv]
// host side model driving the enable pin and the six pwm pins
`timescale 1ns/10ps

module gmc_host_model (
    input wire logic core_clk,
    input wire logic enReq,
    input wire gmc_pkg::gmc_phase_t pwmReq,
    input wire logic floatReq,
    output logic outputEnable,
    output gmc_pkg::gmc_phase_t pwmCmd
);
    // pins follow the requests one edge later; released pins fall to the pull-down level
    always_ff @(posedge core_clk) begin
        if (floatReq) begin
            outputEnable <= 1'b0;
            pwmCmd <= '0;
        end else begin
            outputEnable <= enReq;
            pwmCmd <= pwmReq;
        end
    end
endmodule

// [bench/gmc_gate_enable_mode_control_tb.sv]
// self-checking bench for the gate enable and power mode controller
`timescale 1ns/10ps

module gmc_gate_enable_mode_control_tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic enReq = 1'b0;
    gmc_pkg::gmc_phase_t pwmReq = '0;
    logic floatReq = 1'b1;
    logic wakeIn = 1'b0;
    logic faultActive = 1'b0;
    logic regulatorReady = 1'b0;
    logic sleepSelect = 1'b0;
    logic ampSel = 1'b0;
    // dead-time setting seen by the gate lanes
    logic [7:0] deadCfg = 8'h00;
    logic outputEnable;
    gmc_pkg::gmc_phase_t pwmCmd;
    gmc_pkg::gmc_gate_t gateDrive;
    logic faultPinOut, faultPinOe_n, bootEn, pumpEn, ampEn, regEn;
    // fault wire has a pull-up; low only while pulled
    wire logic faultWire = faultPinOe_n ? 1'b1 : faultPinOut;
    int error_cnt = 0;
    int total_checks = 0;
    int n;

    // clock at 4 ns period
    initial begin
        forever #2 core_clk = ~core_clk;
    end

    gmc_host_model host_u (.core_clk(core_clk), .enReq(enReq), .pwmReq(pwmReq), .floatReq(floatReq),
        .outputEnable(outputEnable), .pwmCmd(pwmCmd));

    gmc_gate_enable_mode_control #(.LOW_TIME_CYCLES(20)) dut_u (.core_clk(core_clk), .reset(reset),
        .outputEnable(outputEnable), .pwmCmd(pwmCmd), .wakeIn(wakeIn), .faultActive(faultActive),
        .regulatorReady(regulatorReady), .sleepSelect(sleepSelect), .amplifier_shutdown_select(ampSel),
        .deadTimeCfg(deadCfg), .faultPinIn(faultWire), .gateDrive(gateDrive), .faultPinOut(faultPinOut),
        .faultPinOe_n(faultPinOe_n), .bootstrapSupplyEn(bootEn), .chargePumpEn(pumpEn),
        .amplifierEn(ampEn), .regulatorEn(regEn));

    // wait a number of rising edges
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
    endtask

    // count one comparison; a mismatch prints both values
    task automatic tally(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // gate outputs, looked at mid-cycle; returns on the next rising edge
    task automatic chk_gate(input logic [5:0] exp);
        @(negedge core_clk);
        tally({2'h0, gateDrive}, {2'h0, exp});
        @(posedge core_clk);
    endtask

    // supplies packed as boot, pump, amp, regulator; looked at mid-cycle
    task automatic chk_sup(input logic [3:0] exp);
        @(negedge core_clk);
        tally({4'h0, bootEn, pumpEn, ampEn, regEn}, {4'h0, exp});
        @(posedge core_clk);
    endtask

    // fault pin packed as enable_n, level, wire; looked at mid-cycle
    task automatic chk_fault(input logic [2:0] exp);
        @(negedge core_clk);
        tally({5'h00, faultPinOe_n, faultPinOut, faultWire}, {5'h00, exp});
        @(posedge core_clk);
    endtask

    // a flag worked out by the scenario itself
    task automatic chk_flag(input logic got, input logic exp);
        @(negedge core_clk);
        tally({7'h00, got}, {7'h00, exp});
        @(posedge core_clk);
    endtask

    // start-up: fault pulled low until regulator ready, enable undriven reads low
    task automatic test_startup();
        tick(5);
        chk_fault(3'h0);
        chk_gate(6'h00);
        regulatorReady <= 1'b1;
        tick(4);
        chk_fault(3'h5);
        $display("test startup done");
    endtask

    // active drive: dead time delays turn-on, overlap blocks both, float reads low
    task automatic test_active();
        floatReq <= 1'b0;
        enReq <= 1'b1;
        pwmReq <= 6'h27;
        deadCfg <= 8'h04;
        tick(7);
        chk_gate(6'h00);
        chk_gate(6'h24);
        chk_sup(4'hF);
        floatReq <= 1'b1;
        deadCfg <= 8'h00;
        tick(6);
        chk_gate(6'h00);
        floatReq <= 1'b0;
        tick(6);
        $display("test active done");
    endtask

    // enable fall turns gates off fast; short pulse keeps the device awake
    task automatic test_short_low();
        enReq <= 1'b0;
        n = 0;
        @(negedge core_clk);
        while (gateDrive !== 6'h00 && n < 30) begin
            @(negedge core_clk);
            n++;
        end
        chk_flag(n < 25, 1'b1);
        tick(8);
        enReq <= 1'b1;
        tick(30);
        chk_sup(4'hF);
        enReq <= 1'b0;
        tick(15);
        enReq <= 1'b1;
        tick(2);
        enReq <= 1'b0;
        tick(15);
        chk_sup(4'hF);
        enReq <= 1'b1;
        tick(8);
        $display("test short low done");
    endtask

    // long low enters standby only after the full low time; amplifiers follow the select
    task automatic test_standby();
        enReq <= 1'b0;
        tick(24);
        chk_sup(4'hF);
        tick(7);
        chk_sup(4'h3);
        ampSel <= 1'b1;
        tick(4);
        chk_sup(4'h1);
        enReq <= 1'b1;
        tick(6);
        chk_sup(4'hF);
        ampSel <= 1'b0;
        $display("test standby done");
    endtask

    // fault latch clears on enable rise only once the fault is gone
    task automatic test_fault();
        faultActive <= 1'b1;
        tick(3);
        chk_fault(3'h0);
        enReq <= 1'b0;
        tick(3);
        enReq <= 1'b1;
        tick(8);
        chk_fault(3'h0);
        faultActive <= 1'b0;
        enReq <= 1'b0;
        tick(3);
        enReq <= 1'b1;
        tick(8);
        chk_fault(3'h5);
        $display("test fault done");
    endtask

    // sleep select picks sleep; a wake rise after a short low is refused, after a long low it wakes
    task automatic test_sleep();
        sleepSelect <= 1'b1;
        enReq <= 1'b0;
        wakeIn <= 1'b1;
        tick(31);
        chk_sup(4'h0);
        enReq <= 1'b1;
        wakeIn <= 1'b0;
        tick(10);
        chk_sup(4'h0);
        wakeIn <= 1'b1;
        tick(4);
        chk_sup(4'h0);
        wakeIn <= 1'b0;
        tick(gmc_pkg::WAKE_SETUP_CYCLES + 8);
        wakeIn <= 1'b1;
        tick(8);
        chk_sup(4'hF);
        wakeIn <= 1'b0;
        sleepSelect <= 1'b0;
        tick(10);
        chk_sup(4'hF);
        $display("test sleep done");
    endtask

    // print counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end

    // main sequence
    initial begin
        tick(20);
        reset <= 1'b0;
        test_startup();
        test_active();
        test_short_low();
        test_standby();
        test_fault();
        test_sleep();
        summarize();
    end
endmodule
